/* design/scrl_top.v */
// Card receive status, receive data and contact line control
// ==========================================================
// Notes on behaviour
// RULE1: Parity error flag sets, clears on read, interrupts
// RULE2: Received bytes go into FIFO, read-only register
// RULE3: Non-sync: control bit one drives reset low
// RULE4: Firmware may stretch reset; keep zero in autosequence
// RULE5: Sync mode: reset line follows control bit
// RULE6: Reading I/O bit returns live line state
// RULE7: Bypass: written I/O bit drives the line
// RULE8: Sync: I/O bit holds card clock capture
// RULE9: Direction bit: one input, zero output; the line is driven only in bypass or sync mode
// RULE10: Contact eight: drive stored, read pin as input
// RULE11: Contact four behaves as contact eight
// RULE12: Clock rests at level bit; bypass drives directly
// RULE13: Stop bit zero runs clock, one halts
// RULE14: Bypass ignores clock stop bit
// RULE15: Each data read pops the oldest byte
`timescale 1ns/1ns
`include "scrl_consts.vh"
// ==========================================================
// Register map, byte wide; unmapped reads return zero
// 0xFE08 receive status, a read clears both error bits
//    bit 0  parity error, sticky until read
//    bit 1  overrun, byte lost on a full FIFO
//    bit 2  FIFO empty, live
//    bit 3  FIFO full, live
// 0xFE09 receive data, a read pops the oldest byte
// 0xFE0A line control
//    bit 7  card reset assert, sense flips in sync mode
//    bit 6  unused, reads zero
//    bit 5  I/O level, reads the line or the sync capture
//    bit 4  I/O direction, one is input
//    bit 3  contact eight level
//    bit 2  contact four level
//    bit 1  clock rest level
//    bit 0  clock stop
// 0xFE20 interrupt status, write one to clear
//    bit 0  receive error, parity or overrun
//    bit 1  byte stored in the FIFO
// 0xFE21 interrupt mask, same layout, one enables
// 0xFE22 mode: 0 normal, 1 bypass, 2 sync; 3 acts as normal
// ==========================================================
// Timing seen from the register port
// Read data stand only in the cycle after the read strobe
// Pins move two cycles after a write: register, then pin flop
// The irq output trails its status bit by one cycle
// The card clock half period is a fixed count of system clocks
// Sync capture lands one cycle after the card clock rises
// Pin reads are not synchronised, so a read of a moving line
// may return either level; firmware should read twice
// A byte arriving on a full FIFO is dropped, never overwritten
module scrl_top #(
   parameter FIFO_DEPTH_LOG2 = 4
) (
   input  wire        clk,
   input  wire        reset,
   // Register port
   input  wire [15:0] addr,
   input  wire [7:0]  wdata,
   input  wire        wr,
   input  wire        rd,
   output reg  [7:0]  rdata,
   // Receive character stream from the receiver core
   input  wire        rx_byte_valid,
   input  wire [7:0]  rx_byte,
   input  wire        rx_parity_bad,
   // Auxiliary contact directions from the pad configuration
   input  wire        c8_is_output,
   input  wire        c4_is_output,
   // Contact pins
   output reg         card_rst,
   input  wire        card_io_in,
   output reg         card_io_out,
   output reg         card_io_oe,
   input  wire        aux8_in,
   output reg         aux8_out,
   output reg         aux8_oe,
   input  wire        aux4_in,
   output reg         aux4_out,
   output reg         aux4_oe,
   output reg         card_clk,
   output reg         irq
);
   // ==========================================================
   // State
   // Receive flags
   reg        rx_parity_error_flag_reg;
   reg        rx_overrun_reg;

   // Line control and sync capture
   reg [7:0]  card_line_control_reg;
   reg        io_sync_capture_reg;

   // Interrupts and mode
   reg [1:0]  int_stat_reg;
   reg [1:0]  int_mask_reg;
   reg [1:0]  mode_reg;

   // Card clock divider and edge detector
   reg [7:0]  div_cnt_reg;
   reg        clk_phase_reg;
   reg        clk_prev_reg;

   // Read path
   reg [7:0]  rdata_next;

   wire [7:0] fifo_data;
   wire       fifo_empty;
   wire       fifo_full;
   wire       fifo_overrun;

   wire is_bypass = (mode_reg == `SCRL_MODE_BYPASS);
   wire is_sync   = (mode_reg == `SCRL_MODE_SYNC);

   // Function shared by both auxiliary contacts: output reads stored, input reads pin
   function aux_read;
      input is_out;
      input stored;
      input pin;
      begin
         aux_read = is_out ? stored : pin;
      end
   endfunction

   // Address match shared by every register strobe
   function reg_hit;
      input        strobe;
      input [15:0] a;
      input [15:0] target;
      begin
         reg_hit = strobe && (a == target);
      end
   endfunction

   // ==========================================================
   // Register strobes, decoded once so every process sees one copy
   wire rd_status   = reg_hit(rd, addr, `SCRL_ADDR_RX_STATUS);
   wire rd_data     = reg_hit(rd, addr, `SCRL_ADDR_RX_DATA);
   wire wr_line     = reg_hit(wr, addr, `SCRL_ADDR_LINE_CTL);
   wire wr_int_stat = reg_hit(wr, addr, `SCRL_ADDR_INT_STAT);
   wire wr_int_mask = reg_hit(wr, addr, `SCRL_ADDR_INT_MASK);
   wire wr_mode     = reg_hit(wr, addr, `SCRL_ADDR_MODE);

   // ==========================================================
   // Receive FIFO
   scrl_rx_fifo #(
      .WIDTH      (8),
      .DEPTH_LOG2 (FIFO_DEPTH_LOG2)
   ) u_fifo (
      .clk      (clk),
      .reset    (reset),
      .wr_valid (rx_byte_valid),
      .wr_data  (rx_byte),
      .rd_pop   (rd_data),   // RULE15
      .rd_data  (fifo_data),
      .empty    (fifo_empty),
      .full     (fifo_full),
      .overrun  (fifo_overrun)
   );

   // ==========================================================
   // Receive flags; a new event in the read cycle wins over read-clear
   always @(posedge clk)
   begin
      if (reset)
      begin
         rx_parity_error_flag_reg <= 1'b0;
         rx_overrun_reg           <= 1'b0;
      end
      else
      begin
         if (rx_byte_valid && rx_parity_bad)
            rx_parity_error_flag_reg <= 1'b1;   // RULE1
         else if (rd_status)
            rx_parity_error_flag_reg <= 1'b0;   // RULE1
         // Overrun shares the read-clear of the parity flag
         if (fifo_overrun)
            rx_overrun_reg <= 1'b1;
         else if (rd_status)
            rx_overrun_reg <= 1'b0;
      end
   end

   // ==========================================================
   // Interrupt status, write one to clear; set beats clear
   wire [1:0] int_events = {rx_byte_valid && !fifo_full,
                            (rx_byte_valid && rx_parity_bad) || fifo_overrun};
   always @(posedge clk)
   begin
      if (reset)
      begin
         int_stat_reg <= 2'h0;
         int_mask_reg <= 2'h0;
         mode_reg     <= `SCRL_MODE_NORMAL;
         irq          <= 1'b0;
      end
      else
      begin
         // Events are ORed in after the clear so a new one is never lost
         if (wr_int_stat)
            int_stat_reg <= (int_stat_reg & ~wdata[1:0]) | int_events;
         else
            int_stat_reg <= int_stat_reg | int_events;   // RULE1
         // Mask and mode are plain read/write registers
         if (wr_int_mask)
            int_mask_reg <= wdata[1:0];
         if (wr_mode)
            mode_reg <= wdata[1:0];
         // Registered, so irq trails the status bit by one cycle
         irq <= |(int_stat_reg & int_mask_reg);
      end
   end

   // ==========================================================
   // Line control register; writes always store, pins decide below
   always @(posedge clk)
   begin
      if (reset)
         card_line_control_reg <= `SCRL_LC_RESET;
      else if (wr_line)
         card_line_control_reg <= wdata & 8'hBF;   // RULE10 RULE11
   end

   // ==========================================================
   // Card clock generator; halted clock rests at the level bit
   wire clk_run = !card_line_control_reg[`SCRL_LC_STOP];   // RULE13
   always @(posedge clk)
   begin
      if (reset)
      begin
         div_cnt_reg   <= 8'h00;
         clk_phase_reg <= 1'b0;
      end
      else if (clk_run && !is_bypass)
      begin
         // Toggle once per half period of the card clock
         if (div_cnt_reg == `SCRL_CLK_HALF - 8'h01)
         begin
            div_cnt_reg   <= 8'h00;
            clk_phase_reg <= ~clk_phase_reg;
         end
         else
            div_cnt_reg <= div_cnt_reg + 8'h01;
      end
      else
      begin
         // Restart from the rest level so the first edge is clean
         div_cnt_reg   <= 8'h00;
         clk_phase_reg <= card_line_control_reg[`SCRL_LC_LVL];
      end
   end

   // ==========================================================
   // Pin drivers, all registered
   always @(posedge clk)
   begin
      if (reset)
      begin
         card_rst     <= 1'b1;
         card_io_out  <= 1'b0;
         card_io_oe   <= 1'b0;
         aux8_out     <= 1'b0;
         aux8_oe      <= 1'b0;
         aux4_out     <= 1'b0;
         aux4_oe      <= 1'b0;
         card_clk     <= 1'b0;
         clk_prev_reg <= 1'b0;
         io_sync_capture_reg <= 1'b0;
      end
      else
      begin
         // Reset sense flips in sync mode
         if (is_sync)
            card_rst <= card_line_control_reg[`SCRL_LC_RST];    // RULE5
         else
            card_rst <= ~card_line_control_reg[`SCRL_LC_RST];   // RULE3 RULE4
         // Direction bit only means anything in bypass or sync
         // Normal mode leaves the line to the transmitter, so never drive
         card_io_oe  <= (is_bypass || is_sync) &&
                        !card_line_control_reg[`SCRL_LC_DIR];   // RULE9
         card_io_out <= card_line_control_reg[`SCRL_LC_IO];     // RULE7
         // Contacts follow the pad direction; stored bits always reach the flop
         aux8_oe  <= c8_is_output;                                // RULE10
         aux8_out <= card_line_control_reg[`SCRL_LC_C8];          // RULE10
         aux4_oe  <= c4_is_output;                                // RULE11
         aux4_out <= card_line_control_reg[`SCRL_LC_C4];          // RULE11
         // Bypass hands the clock to the level bit alone
         if (is_bypass)
            card_clk <= card_line_control_reg[`SCRL_LC_LVL];     // RULE12 RULE14
         else
            card_clk <= clk_run ? clk_phase_reg
                                : card_line_control_reg[`SCRL_LC_LVL];   // RULE12 RULE13
         // Rising edge of the pin flop, seen one cycle late
         clk_prev_reg <= card_clk;
         if (card_clk && !clk_prev_reg)
            io_sync_capture_reg <= card_io_in;   // RULE8
      end
   end

   // ==========================================================
   // Read mux; the pin samples are deliberately not synchronised
   always @*
   begin
      // Unmapped addresses fall through to zero
      rdata_next = 8'h00;
      if (addr == `SCRL_ADDR_RX_STATUS)
         rdata_next = {4'h0, fifo_full, fifo_empty, rx_overrun_reg,
                       rx_parity_error_flag_reg};   // RULE1
      else if (addr == `SCRL_ADDR_RX_DATA)
         rdata_next = fifo_empty ? 8'h00 : fifo_data;   // RULE2
      else if (addr == `SCRL_ADDR_LINE_CTL)
      begin
         // Pin bits replace the stored ones on the way out: I/O line (sync capture in sync mode), contacts only as inputs
         rdata_next = card_line_control_reg;
         rdata_next[`SCRL_LC_IO] = is_sync ? io_sync_capture_reg
                                           : card_io_in;   // RULE6 RULE8
         rdata_next[`SCRL_LC_C8] = aux_read(c8_is_output,
                                            card_line_control_reg[`SCRL_LC_C8],
                                            aux8_in);   // RULE10
         rdata_next[`SCRL_LC_C4] = aux_read(c4_is_output,
                                            card_line_control_reg[`SCRL_LC_C4],
                                            aux4_in);   // RULE11
      end
      else if (addr == `SCRL_ADDR_INT_STAT)
         rdata_next = {6'h00, int_stat_reg};
      else if (addr == `SCRL_ADDR_INT_MASK)
         rdata_next = {6'h00, int_mask_reg};
      else if (addr == `SCRL_ADDR_MODE)
         rdata_next = {6'h00, mode_reg};
   end

   // Read data valid only in the cycle after the strobe
   // Zero between reads keeps stale data off the bus
   always @(posedge clk)
   begin
      if (reset)
         rdata <= 8'h00;
      else if (rd)
         rdata <= rdata_next;
      else
         rdata <= 8'h00;
   end
endmodule

/* shared/scrl_consts.vh */
// Register map, field positions, reset values and timing for the card receive/line block
`ifndef SCRL_CONSTS_VH
`define SCRL_CONSTS_VH
// Register addresses
`define SCRL_ADDR_W         16
`define SCRL_ADDR_RX_STATUS 16'hFE08
`define SCRL_ADDR_RX_DATA   16'hFE09
`define SCRL_ADDR_LINE_CTL  16'hFE0A
`define SCRL_ADDR_INT_STAT  16'hFE20
`define SCRL_ADDR_INT_MASK  16'hFE21
`define SCRL_ADDR_MODE      16'hFE22
// Line control fields
`define SCRL_LC_RST   7
`define SCRL_LC_IO    5
`define SCRL_LC_DIR   4
`define SCRL_LC_C8    3
`define SCRL_LC_C4    2
`define SCRL_LC_LVL   1
`define SCRL_LC_STOP  0
`define SCRL_LC_RESET 8'h21
// Receive status fields
`define SCRL_RS_PAR   0
`define SCRL_RS_OVR   1
`define SCRL_RS_EMPTY 2
`define SCRL_RS_FULL  3
// Interrupt status fields
`define SCRL_INT_RX_ERROR 0
`define SCRL_INT_RXDATA 1
// Mode field values
`define SCRL_MODE_NORMAL 2'h0
`define SCRL_MODE_BYPASS 2'h1
`define SCRL_MODE_SYNC   2'h2
// Card clock divider: half period in system clocks
`define SCRL_CLK_HALF 8'h02
`endif

/* design/scrl_rx_fifo.v */
// Receive byte FIFO for the card receive path
`timescale 1ns/1ns
module scrl_rx_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH_LOG2 = 4
) (
   input  wire             clk,
   input  wire             reset,
   input  wire             wr_valid,
   input  wire [WIDTH-1:0] wr_data,
   input  wire             rd_pop,
   output wire [WIDTH-1:0] rd_data,
   output wire             empty,
   output wire             full,
   output wire             overrun
);
   localparam DEPTH = 1 << DEPTH_LOG2;
   reg [WIDTH-1:0]      mem_reg [0:DEPTH-1];
   reg [DEPTH_LOG2:0]   wptr_reg;
   reg [DEPTH_LOG2:0]   rptr_reg;

   assign empty = (wptr_reg == rptr_reg);
   assign full  = (wptr_reg[DEPTH_LOG2-1:0] == rptr_reg[DEPTH_LOG2-1:0]) &&
                  (wptr_reg[DEPTH_LOG2] != rptr_reg[DEPTH_LOG2]);
   assign overrun = wr_valid && full;
   assign rd_data = mem_reg[rptr_reg[DEPTH_LOG2-1:0]];

   // ==========================================================
   // Pointers; a byte arriving while full is dropped, not stored
   always @(posedge clk)
   begin
      if (reset)
      begin
         wptr_reg <= {(DEPTH_LOG2+1){1'b0}};
         rptr_reg <= {(DEPTH_LOG2+1){1'b0}};
      end
      else
      begin
         if (wr_valid && !full)
         begin
            mem_reg[wptr_reg[DEPTH_LOG2-1:0]] <= wr_data;   // RULE2
            wptr_reg <= wptr_reg + 1'b1;
         end
         if (rd_pop && !empty)
            rptr_reg <= rptr_reg + 1'b1;   // RULE15
      end
   end
endmodule

/* verification/scrl_top_asserts.sv */
// Concurrent checks on the card line control block ports
`timescale 1ns/1ns
module scrl_top_asserts (
   input logic        clk,
   input logic        reset,
   input logic [15:0] addr,
   input logic [7:0]  wdata,
   input logic        wr,
   input logic        rd,
   input logic [7:0]  rdata,
   input logic        rx_byte_valid,
   input logic        rx_parity_bad,
   input logic        card_rst,
   input logic        card_io_oe,
   input logic        aux8_out,
   input logic        aux8_oe,
   input logic        card_clk,
   input logic        irq
);
   logic [7:0] lc_reg;
   logic [1:0] mode_reg;
   logic       mask_reg;
   wire        byp = mode_reg == 2'h1;
   wire        run = !byp && !lc_reg[0];
   wire        st_rd = rd && addr == 16'hFE08 && !rx_byte_valid;
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   // =========================================================
   // Shadow registers rebuilt from writes, since only ports are visible
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         lc_reg <= 8'h21;
         mode_reg <= 2'h0;
         mask_reg <= 1'b0;
      end
      else if (wr)
      begin
         if (addr == 16'hFE0A) lc_reg <= wdata;
         if (addr == 16'hFE22) mode_reg <= wdata[1:0];
         if (addr == 16'hFE21) mask_reg <= wdata[0];
      end
   end
   // =========================================================
   // Pins trail the register by one pin flop
   property p_rst_pin;
      !$past(reset) |-> card_rst == ($past(mode_reg) == 2'h2 ^ !$past(lc_reg[7]));
   endproperty
   a_rst_pin: assert property (p_rst_pin) else $error("reset pin level");
   property p_io_dir;
      !$past(reset) |-> card_io_oe == ($past(byp || mode_reg == 2'h2) && !$past(lc_reg[4]));
   endproperty
   a_io_dir: assert property (p_io_dir) else $error("io direction");
   property p_aux8;
      aux8_oe && !$past(reset) |-> aux8_out == $past(lc_reg[3]);
   endproperty
   a_aux8: assert property (p_aux8) else $error("contact eight level");
   property p_clk_byp;
      $past(byp) && !$past(reset) |-> card_clk == $past(lc_reg[1]);
   endproperty
   a_clk_byp: assert property (p_clk_byp) else $error("bypass clock");
   property p_clk_stop;
      $past(lc_reg[0] && !byp) && !$past(reset) |-> card_clk == $past(lc_reg[1]);
   endproperty
   a_clk_stop: assert property (p_clk_stop) else $error("stopped clock level");
   // Running clock must toggle; a stuck divider would hold it
   property p_clk_run;
      run[*3] |-> ##[0:3] $changed(card_clk);
   endproperty
   a_clk_run: assert property (p_clk_run) else $error("clock not running");
   property p_irq_par;
      rx_byte_valid && rx_parity_bad && mask_reg |-> ##[1:3] irq;
   endproperty
   a_irq_par: assert property (p_irq_par) else $error("no error interrupt");
   property p_par_clear;
      st_rd ##1 !rx_byte_valid ##1 st_rd |=> !rdata[0];
   endproperty
   a_par_clear: assert property (p_par_clear) else $error("parity flag kept");
endmodule
bind scrl_top scrl_top_asserts u_chk (.clk, .reset, .addr, .wdata, .wr, .rd, .rdata,
   .rx_byte_valid, .rx_parity_bad, .card_rst, .card_io_oe, .aux8_out, .aux8_oe, .card_clk, .irq);

/* verification/scrl_card_model.sv */
// Behavioural card answering on its data contact
`timescale 1ns/1ns
module scrl_card_model (
   input  logic card_clk,
   input  logic card_rst,
   output logic io_drv
);
   logic [7:0] shift_reg = 8'h55;
   // Shift on the falling edge so the bit is settled at the rising edge
   always @(negedge card_clk)
   begin
      if (card_rst)
         shift_reg <= {shift_reg[6:0], shift_reg[7]};
   end
   assign io_drv = shift_reg[7];
endmodule

/* verification/tb.sv */
// Self-checking bench for the card line control block
`timescale 1ns/1ns
module tb;
   logic        clk = 1'b0, reset = 1'b1, wr = 1'b0, rd = 1'b0, cap = 1'b0;
   logic        rx_byte_valid = 1'b0, rx_parity_bad = 1'b0, aux8_in = 1'b1, aux4_in = 1'b1;
   logic        c8_is_output = 1'b1, c4_is_output = 1'b1;
   logic [15:0] addr = 16'h0000;
   logic [7:0]  wdata = 8'h00, rx_byte = 8'h00, e;
   wire  [7:0]  rdata;
   wire         card_rst, card_io_out, card_io_oe, aux8_out, aux8_oe, aux4_out, aux4_oe;
   wire         card_clk, irq, io_drv;
   wire         io_line = card_io_oe ? card_io_out : io_drv;
   int          n_fail = 0, n_checks = 0, edges = 0;
   scrl_top i_dut (.clk, .reset, .addr, .wdata, .wr, .rd, .rdata, .rx_byte_valid, .rx_byte,
      .rx_parity_bad, .c8_is_output, .c4_is_output, .card_rst, .card_io_in(io_line),
      .card_io_out, .card_io_oe, .aux8_in, .aux8_out, .aux8_oe, .aux4_in, .aux4_out,
      .aux4_oe, .card_clk, .irq);
   scrl_card_model i_card (.card_clk, .card_rst, .io_drv);
   // 100 MHz clock
   initial forever #5 clk = ~clk;
   // Line level at each rising card clock, for the sync capture
   always @(posedge card_clk)
   begin
      cap <= io_line;
      edges++;
   end
   // =========================================================
   // Access tasks
   task automatic end_sim;
      $display("checks %0d failures %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   // Returns once the pin flop has taken the new value
   task automatic wr_reg(input logic [15:0] a, input logic [7:0] v);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      repeat (2) @(posedge clk);
   endtask
   task automatic rd_chk(input logic [15:0] a, input logic [7:0] m, input logic [7:0] x);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(posedge clk);
      chk(rdata & m, x);
   endtask
   task automatic push(input logic [7:0] b, input logic p);
      rx_byte <= b;
      rx_parity_bad <= p;
      rx_byte_valid <= 1'b1;
      @(posedge clk);
      rx_byte_valid <= 1'b0;
      @(posedge clk);
   endtask
   // =========================================================
   // Main sequence
   initial
   begin
      repeat (3) @(posedge clk);
      reset <= 1'b0;
      rd_chk(16'hFE0A, 8'hFF, {2'b00, io_line, 5'h01});
      rd_chk(16'hFE0F, 8'hFF, 8'h00);
      for (int i = 0; i < 3; i++)
         push(8'hC0 + 8'(i), 1'b0);
      wr_reg(16'hFE09, 8'hFF);
      for (int i = 0; i < 4; i++)
         rd_chk(16'hFE09, 8'hFF, i < 3 ? 8'hC0 + 8'(i) : 8'h00);
      wr_reg(16'hFE21, 8'h01);
      push(8'h5A, 1'b1);
      @(posedge clk);
      chk({7'h00, irq}, 8'h01);
      rd_chk(16'hFE08, 8'hFB, 8'h01);
      rd_chk(16'hFE08, 8'hFB, 8'h00);
      rd_chk(16'hFE20, 8'h01, 8'h01);
      wr_reg(16'hFE21, 8'h00);
      chk({7'h00, irq}, 8'h00);
      wr_reg(16'hFE21, 8'h01);
      wr_reg(16'hFE20, 8'h03);
      chk({7'h00, irq}, 8'h00);
      // Reset pin sense in normal and sync modes
      for (int k = 0; k < 4; k++)
      begin
         wr_reg(16'hFE22, k[1] ? 8'h02 : 8'h00);
         wr_reg(16'hFE0A, {k[0], 7'h11});
         chk({7'h00, card_rst}, {7'h00, k[1] ? k[0] : !k[0]});
      end
      wr_reg(16'hFE0A, 8'h90);
      repeat (20) @(posedge clk);
      chk({7'h00, edges > 0}, 8'h01);
      wr_reg(16'hFE0A, 8'h91);
      edges = 0;
      repeat (10) @(posedge clk);
      chk({6'h00, card_clk, edges > 0}, 8'h00);
      rd_chk(16'hFE0A, 8'h20, {2'b00, cap, 5'h00});
      wr_reg(16'hFE22, 8'h00);
      wr_reg(16'hFE0A, 8'h13);
      chk({7'h00, card_clk}, 8'h01);
      // Bypass: stop bit clear yet the clock only follows the level bit
      wr_reg(16'hFE22, 8'h01);
      for (int v = 0; v < 4; v++)
      begin
         wr_reg(16'hFE0A, {2'b00, v[0], 3'h0, v[1], 1'b0});
         chk({card_io_oe, card_io_out, card_clk}, {6'h01, v[0], v[1]});
         rd_chk(16'hFE0A, 8'h20, {2'b00, v[0], 5'h00});
      end
      wr_reg(16'hFE0A, 8'h10);
      chk({7'h00, card_io_oe}, 8'h00);
      // Contacts four and eight, driven or sampled, pins opposite to stored bits
      wr_reg(16'hFE22, 8'h00);
      for (int k = 0; k < 8; k++)
      begin
         c8_is_output <= k[0];
         c4_is_output <= k[1];
         aux8_in <= !k[2];
         aux4_in <= !k[2];
         wr_reg(16'hFE0A, {4'h1, k[2], k[2], 2'b01});
         e = {4'h0, k[0], k[1], k[2] | !k[0], k[2] | !k[1]};
         chk({aux8_oe, aux4_oe, aux8_out | !k[0], aux4_out | !k[1]}, e);
         e = {4'h0, k[0] ~^ k[2], k[1] ~^ k[2], 2'b00};
         rd_chk(16'hFE0A, 8'h0C, e);
      end
      // Drain, then fill past the depth: the extra byte is dropped and flagged
      rd_chk(16'hFE09, 8'hFF, 8'h5A);
      rd_chk(16'hFE08, 8'h0F, 8'h04);
      for (int i = 0; i < 17; i++)
         push(8'h30 + 8'(i), 1'b0);
      rd_chk(16'hFE08, 8'h0F, 8'h0A);
      rd_chk(16'hFE08, 8'h0F, 8'h08);
      rd_chk(16'hFE20, 8'h03, 8'h03);
      rd_chk(16'hFE09, 8'hFF, 8'h30);
      end_sim;
   end
   // Cut a hung run short
   initial
   begin
      repeat (20000) @(posedge clk);
      n_fail++;
      end_sim;
   end
endmodule
